// ===== rtl/pmt_cfg.svh
// named constants for the paging mode and translation control block
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// control register bit positions
`define PMT_CR0_TRANS_BIT 31
`define PMT_CR4_LARGE_BIT 4
`define PMT_CR4_EXT_BIT 5

// identification answer
`define PMT_ID_WIDE_BIT 17
`define PMT_ID_LEAF_ONE 32'h00000001
`define PMT_ID_ZERO 32'h00000000

// directory and table entry fields
`define PMT_ENT_PRESENT_BIT 0
`define PMT_ENT_SIZE_BIT 7
`define PMT_WIDE_HI_LSB 13
`define PMT_WIDE_HI_MSB 16

// physical address width and frame width (4-KByte granules)
`define PMT_PA_W 36
`define PMT_FRAME_W 24
`define PMT_VPN_W 20

// tag masks per page size, in 4-KByte page numbers
`define PMT_MASK_4K 20'hfffff
`define PMT_MASK_2M 20'hffe00
`define PMT_MASK_4M 20'hffc00

// entries held by each lookaside buffer
`define PMT_TLB_N 4
`define PMT_TLB_PTR_W 2

`endif

// ===== rtl/pmt_pkg.sv
// types shared by the paging translation block and its lookaside buffers
package pmt_pkg;

  typedef enum logic [1:0] {
    pmt_sz_4k = 2'h0,
    pmt_sz_2m = 2'h1,
    pmt_sz_4m = 2'h2,
    pmt_sz_none = 2'h3
  } pmt_size_e;

  typedef enum logic [5:0] {
    pmt_st_idle = 6'h01,
    pmt_st_lookup = 6'h02,
    pmt_st_rd_ptr = 6'h04,
    pmt_st_rd_dir = 6'h08,
    pmt_st_rd_tab = 6'h10,
    pmt_st_fault = 6'h20
  } pmt_state_e;

endpackage

// ===== rtl/pmt_tlb_if.sv
// lookup and fill signals between the walker and one lookaside buffer
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

interface pmt_tlb_if;
  logic [`PMT_VPN_W-1:0] lookup_vpn;
  logic hit;
  logic [`PMT_FRAME_W-1:0] hit_frame;
  pmt_pkg::pmt_size_e hit_size;
  logic fill_valid;
  logic [`PMT_VPN_W-1:0] fill_vpn;
  logic [`PMT_FRAME_W-1:0] fill_frame;
  pmt_pkg::pmt_size_e fill_size;
  logic flush;

  modport store (
    input lookup_vpn,
    input fill_valid,
    input fill_vpn,
    input fill_frame,
    input fill_size,
    input flush,
    output hit,
    output hit_frame,
    output hit_size
  );

  modport user (
    output lookup_vpn,
    output fill_valid,
    output fill_vpn,
    output fill_frame,
    output fill_size,
    output flush,
    input hit,
    input hit_frame,
    input hit_size
  );
endinterface

`default_nettype wire

// ===== rtl/pmt_tlb.sv
// small fully associative lookaside buffer with round-robin replacement
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_tlb (
  input wire logic core_clk,
  input wire logic rst,
  pmt_tlb_if.store tlb
);

  logic valid_ff [`PMT_TLB_N];
  logic [`PMT_VPN_W-1:0] tag_ff [`PMT_TLB_N];
  logic [`PMT_FRAME_W-1:0] frame_ff [`PMT_TLB_N];
  pmt_pkg::pmt_size_e size_ff [`PMT_TLB_N];
  logic [`PMT_TLB_PTR_W-1:0] ptr_ff;
  logic nxt_valid [`PMT_TLB_N];
  logic [`PMT_VPN_W-1:0] nxt_tag [`PMT_TLB_N];
  logic [`PMT_FRAME_W-1:0] nxt_frame [`PMT_TLB_N];
  pmt_pkg::pmt_size_e nxt_size [`PMT_TLB_N];
  logic [`PMT_TLB_PTR_W-1:0] nxt_ptr;
  logic [`PMT_VPN_W-1:0] mask;

  // =====================================================
  // lookup
  always_comb begin
    tlb.hit = 1'b0;
    tlb.hit_frame = '0;
    tlb.hit_size = pmt_pkg::pmt_sz_4k;
    mask = `PMT_MASK_4K;
    for (int i = 0; i < `PMT_TLB_N; i++) begin
      case (size_ff[i])
        pmt_pkg::pmt_sz_2m: mask = `PMT_MASK_2M;
        pmt_pkg::pmt_sz_4m: mask = `PMT_MASK_4M;
        default: mask = `PMT_MASK_4K;
      endcase
      if (!tlb.hit && valid_ff[i] && (((tag_ff[i] ^ tlb.lookup_vpn) & mask) == '0)) begin
        tlb.hit = 1'b1;
        tlb.hit_frame = frame_ff[i];
        tlb.hit_size = size_ff[i];
      end
    end
  end

  // =====================================================
  // fill and flush
  // a flush in the same cycle as a fill wins: the fill may belong to the old mode
  always_comb begin
    nxt_ptr = ptr_ff;
    for (int i = 0; i < `PMT_TLB_N; i++) begin
      nxt_valid[i] = valid_ff[i] && !tlb.flush;
      nxt_tag[i] = tag_ff[i];
      nxt_frame[i] = frame_ff[i];
      nxt_size[i] = size_ff[i];
    end
    if (tlb.fill_valid && !tlb.flush) begin
      nxt_valid[ptr_ff] = 1'b1;
      nxt_tag[ptr_ff] = tlb.fill_vpn;
      nxt_frame[ptr_ff] = tlb.fill_frame;
      nxt_size[ptr_ff] = tlb.fill_size;
      nxt_ptr = ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_ff <= '0;
      for (int i = 0; i < `PMT_TLB_N; i++) begin
        valid_ff[i] <= 1'b0;
        tag_ff[i] <= '0;
        frame_ff[i] <= '0;
        size_ff[i] <= pmt_pkg::pmt_sz_4k;
      end
    end else begin
      ptr_ff <= nxt_ptr;
      for (int i = 0; i < `PMT_TLB_N; i++) begin
        valid_ff[i] <= nxt_valid[i];
        tag_ff[i] <= nxt_tag[i];
        frame_ff[i] <= nxt_frame[i];
        size_ff[i] <= nxt_size[i];
      end
    end
  end

endmodule

`default_nettype wire

// ===== rtl/pmt_top.sv
// paging mode decode, table walk and translation lookaside buffering
//
// Operation
// - translation maps pages of 4K, 2M or 4M
// - non-present page faults, restart after handler return
// - cache entries; read memory only on miss
// - translation enable from control zero bit 31
// - large page enable from control four bit 4
// - address extension from control four bit 5
// - no large, no extension: always 4K pages
// - extension only with translation; pointer table first
// - extension widens to implemented width
// - identification leaf one reports wide scheme, bit 17
// - wide scheme forms 36-bit 4M addresses
// - directory: 1024 entries of 32 bits
// - table: 1024 entries, used only for 4K
// - pointer table of four 64-bit entries
// - size bit 0 table; 1 maps 4M
// - extension with size bit 1 maps 2M
// - otherwise 32-bit physical, 4 GBytes
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_top #(
  // arbitrary default; set per implementation
  parameter logic WIDE_SCHEME_AVAIL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] control_register_zero,
  input wire logic [31:0] control_register_four,
  input wire logic [31:0] dir_base,
  input wire logic tlb_flush,
  input wire logic [31:0] id_leaf,
  output logic [31:0] data_register_d,
  input wire logic req_valid,
  input wire logic [31:0] req_lin,
  output logic req_ready,
  output logic resp_valid,
  output logic [`PMT_PA_W-1:0] resp_phys,
  output pmt_pkg::pmt_size_e resp_size,
  output logic page_fault_exception,
  output logic fault_pending,
  output logic [31:0] fault_lin,
  input wire logic handler_return,
  output logic mem_req,
  output logic [`PMT_PA_W-1:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [63:0] mem_rdata
);

  pmt_tlb_if small_if ();
  pmt_tlb_if large_if ();

  pmt_tlb u_small_tlb (
    .core_clk(core_clk),
    .rst(rst),
    .tlb(small_if)
  );

  pmt_tlb u_large_tlb (
    .core_clk(core_clk),
    .rst(rst),
    .tlb(large_if)
  );

  // =====================================================
  // mode decode
  logic trans_en;
  logic large_en;
  logic ext_en;
  logic wide_en;
  logic [3:0] mode_ff;
  logic [3:0] nxt_mode;
  logic mode_change;
  logic [31:0] data_d_ff;
  logic [31:0] nxt_data_d;

  always_comb begin
    nxt_mode[3] = control_register_zero[`PMT_CR0_TRANS_BIT];
    nxt_mode[2] = control_register_four[`PMT_CR4_LARGE_BIT];
    nxt_mode[1] = control_register_four[`PMT_CR4_EXT_BIT];
    nxt_mode[0] = WIDE_SCHEME_AVAIL;
    nxt_data_d = `PMT_ID_ZERO;
    if (id_leaf == `PMT_ID_LEAF_ONE) begin
      nxt_data_d[`PMT_ID_WIDE_BIT] = WIDE_SCHEME_AVAIL;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_ff <= 4'h0;
      data_d_ff <= 32'h0;
    end else begin
      mode_ff <= nxt_mode;
      data_d_ff <= nxt_data_d;
    end
  end

  // extension and large pages mean nothing while translation is off
  assign trans_en = mode_ff[3];
  assign ext_en = mode_ff[3] && mode_ff[1];
  assign large_en = mode_ff[3] && mode_ff[2];
  assign wide_en = large_en && !mode_ff[1] && mode_ff[0];
  // cached entries were formed under the old mode, so a mode change drops them all
  assign mode_change = (mode_ff != nxt_mode);
  assign data_register_d = data_d_ff;

  // =====================================================
  // walk state machine
  pmt_pkg::pmt_state_e state_ff;
  pmt_pkg::pmt_state_e nxt_state;
  logic [31:0] lin_ff;
  logic [31:0] nxt_lin;
  logic ready_ff;
  logic nxt_ready;
  logic resp_valid_ff;
  logic nxt_resp_valid;
  logic [`PMT_PA_W-1:0] resp_phys_ff;
  logic [`PMT_PA_W-1:0] nxt_resp_phys;
  pmt_pkg::pmt_size_e resp_size_ff;
  pmt_pkg::pmt_size_e nxt_resp_size;
  logic fault_pulse_ff;
  logic nxt_fault_pulse;
  logic fault_pend_ff;
  logic nxt_fault_pend;
  logic mem_req_ff;
  logic nxt_mem_req;
  logic [`PMT_PA_W-1:0] mem_addr_ff;
  logic [`PMT_PA_W-1:0] nxt_mem_addr;
  logic [31:0] ent_lo;
  logic [`PMT_FRAME_W-1:0] wide_frame;

  assign small_if.lookup_vpn = lin_ff[31:12];
  assign large_if.lookup_vpn = lin_ff[31:12];
  assign small_if.flush = tlb_flush || mode_change;
  assign large_if.flush = tlb_flush || mode_change;
  assign ent_lo = mem_rdata[31:0];
  // wide scheme: upper physical bits ride in otherwise reserved directory bits
  assign wide_frame = {ent_lo[`PMT_WIDE_HI_MSB:`PMT_WIDE_HI_LSB], ent_lo[31:22], 10'h0};

  always_comb begin
    nxt_state = state_ff;
    nxt_lin = lin_ff;
    nxt_ready = ready_ff;
    nxt_resp_valid = 1'b0;
    nxt_resp_phys = resp_phys_ff;
    nxt_resp_size = resp_size_ff;
    nxt_fault_pulse = 1'b0;
    nxt_fault_pend = fault_pend_ff;
    nxt_mem_req = 1'b0;
    nxt_mem_addr = mem_addr_ff;
    small_if.fill_valid = 1'b0;
    small_if.fill_vpn = lin_ff[31:12];
    small_if.fill_frame = {4'h0, ent_lo[31:12]};
    small_if.fill_size = pmt_pkg::pmt_sz_4k;
    large_if.fill_valid = 1'b0;
    large_if.fill_vpn = lin_ff[31:12];
    large_if.fill_frame = {4'h0, ent_lo[31:22], 10'h0};
    large_if.fill_size = pmt_pkg::pmt_sz_4m;
    case (state_ff)
      pmt_pkg::pmt_st_idle: begin
        if (req_valid && ready_ff) begin
          nxt_lin = req_lin;
          nxt_ready = 1'b0;
          nxt_state = pmt_pkg::pmt_st_lookup;
        end
      end
      pmt_pkg::pmt_st_lookup: begin
        if (!trans_en) begin
          nxt_resp_phys = {4'h0, lin_ff};
          nxt_resp_size = pmt_pkg::pmt_sz_none;
          nxt_resp_valid = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = pmt_pkg::pmt_st_idle;
        end else if (small_if.hit) begin
          nxt_resp_phys = {small_if.hit_frame, lin_ff[11:0]};
          nxt_resp_size = pmt_pkg::pmt_sz_4k;
          nxt_resp_valid = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = pmt_pkg::pmt_st_idle;
        end else if (large_if.hit) begin
          if (large_if.hit_size == pmt_pkg::pmt_sz_2m) begin
            nxt_resp_phys = {large_if.hit_frame[23:9], lin_ff[20:0]};
          end else begin
            nxt_resp_phys = {large_if.hit_frame[23:10], lin_ff[21:0]};
          end
          nxt_resp_size = large_if.hit_size;
          nxt_resp_valid = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = pmt_pkg::pmt_st_idle;
        end else if (ext_en) begin
          // four 8-byte pointer entries picked by the top two linear bits
          nxt_mem_addr = {4'h0, dir_base[31:5], lin_ff[31:30], 3'h0};
          nxt_mem_req = 1'b1;
          nxt_state = pmt_pkg::pmt_st_rd_ptr;
        end else begin
          // 1024 four-byte directory entries in one 4-KByte page
          nxt_mem_addr = {4'h0, dir_base[31:12], lin_ff[31:22], 2'h0};
          nxt_mem_req = 1'b1;
          nxt_state = pmt_pkg::pmt_st_rd_dir;
        end
      end
      pmt_pkg::pmt_st_rd_ptr: begin
        if (mem_rvalid) begin
          if (!ent_lo[`PMT_ENT_PRESENT_BIT]) begin
            nxt_fault_pulse = 1'b1;
            nxt_fault_pend = 1'b1;
            nxt_state = pmt_pkg::pmt_st_fault;
          end else begin
            // only 36 address bits are implemented here; a wider part widens this slice
            nxt_mem_addr = {mem_rdata[35:12], lin_ff[29:21], 3'h0};
            nxt_mem_req = 1'b1;
            nxt_state = pmt_pkg::pmt_st_rd_dir;
          end
        end
      end
      pmt_pkg::pmt_st_rd_dir: begin
        if (mem_rvalid) begin
          if (!ent_lo[`PMT_ENT_PRESENT_BIT]) begin
            nxt_fault_pulse = 1'b1;
            nxt_fault_pend = 1'b1;
            nxt_state = pmt_pkg::pmt_st_fault;
          end else if (ext_en && ent_lo[`PMT_ENT_SIZE_BIT]) begin
            // 2-MByte page straight from the entry, large enable not consulted
            nxt_resp_phys = {mem_rdata[35:21], lin_ff[20:0]};
            nxt_resp_size = pmt_pkg::pmt_sz_2m;
            large_if.fill_valid = 1'b1;
            large_if.fill_frame = {mem_rdata[35:21], 9'h0};
            large_if.fill_size = pmt_pkg::pmt_sz_2m;
            nxt_resp_valid = 1'b1;
            nxt_ready = 1'b1;
            nxt_state = pmt_pkg::pmt_st_idle;
          end else if (!ext_en && large_en && ent_lo[`PMT_ENT_SIZE_BIT]) begin
            if (wide_en) begin
              nxt_resp_phys = {wide_frame[23:10], lin_ff[21:0]};
              large_if.fill_frame = wide_frame;
            end else begin
              nxt_resp_phys = {4'h0, ent_lo[31:22], lin_ff[21:0]};
            end
            nxt_resp_size = pmt_pkg::pmt_sz_4m;
            large_if.fill_valid = 1'b1;
            nxt_resp_valid = 1'b1;
            nxt_ready = 1'b1;
            nxt_state = pmt_pkg::pmt_st_idle;
          end else if (ext_en) begin
            nxt_mem_addr = {mem_rdata[35:12], lin_ff[20:12], 3'h0};
            nxt_mem_req = 1'b1;
            nxt_state = pmt_pkg::pmt_st_rd_tab;
          end else begin
            // size bit ignored without large pages
            nxt_mem_addr = {4'h0, ent_lo[31:12], lin_ff[21:12], 2'h0};
            nxt_mem_req = 1'b1;
            nxt_state = pmt_pkg::pmt_st_rd_tab;
          end
        end
      end
      pmt_pkg::pmt_st_rd_tab: begin
        if (mem_rvalid) begin
          if (!ent_lo[`PMT_ENT_PRESENT_BIT]) begin
            nxt_fault_pulse = 1'b1;
            nxt_fault_pend = 1'b1;
            nxt_state = pmt_pkg::pmt_st_fault;
          end else begin
            if (ext_en) begin
              nxt_resp_phys = {mem_rdata[35:12], lin_ff[11:0]};
              small_if.fill_frame = mem_rdata[35:12];
            end else begin
              nxt_resp_phys = {4'h0, ent_lo[31:12], lin_ff[11:0]};
            end
            nxt_resp_size = pmt_pkg::pmt_sz_4k;
            small_if.fill_valid = 1'b1;
            nxt_resp_valid = 1'b1;
            nxt_ready = 1'b1;
            nxt_state = pmt_pkg::pmt_st_idle;
          end
        end
      end
      pmt_pkg::pmt_st_fault: begin
        // the same linear address is walked again, as the restarted access would
        if (handler_return) begin
          nxt_fault_pend = 1'b0;
          nxt_state = pmt_pkg::pmt_st_lookup;
        end
      end
      default: begin
        nxt_state = pmt_pkg::pmt_st_idle;
        nxt_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= pmt_pkg::pmt_st_idle;
      lin_ff <= 32'h0;
      ready_ff <= 1'b1;
      resp_valid_ff <= 1'b0;
      resp_phys_ff <= '0;
      resp_size_ff <= pmt_pkg::pmt_sz_none;
      fault_pulse_ff <= 1'b0;
      fault_pend_ff <= 1'b0;
      mem_req_ff <= 1'b0;
      mem_addr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      lin_ff <= nxt_lin;
      ready_ff <= nxt_ready;
      resp_valid_ff <= nxt_resp_valid;
      resp_phys_ff <= nxt_resp_phys;
      resp_size_ff <= nxt_resp_size;
      fault_pulse_ff <= nxt_fault_pulse;
      fault_pend_ff <= nxt_fault_pend;
      mem_req_ff <= nxt_mem_req;
      mem_addr_ff <= nxt_mem_addr;
    end
  end

  assign req_ready = ready_ff;
  assign resp_valid = resp_valid_ff;
  assign resp_phys = resp_phys_ff;
  assign resp_size = resp_size_ff;
  assign page_fault_exception = fault_pulse_ff;
  assign fault_pending = fault_pend_ff;
  assign fault_lin = lin_ff;
  assign mem_req = mem_req_ff;
  assign mem_addr = mem_addr_ff;

endmodule

`default_nettype wire

// ===== dv/pmt_mem_model.sv
// behavioural system memory holding the translation tables
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_mem_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic [`PMT_PA_W-1:0] mem_addr,
  output logic mem_rvalid,
  output logic [63:0] mem_rdata
);
  // ==========================================================
  // table storage, latency knob and read counter
  logic [63:0] tab [logic [`PMT_PA_W-1:0]];
  logic [`PMT_PA_W-1:0] addr_q;
  int lat = 1;
  int cnt = 0;
  int n_reads = 0;

  // ==========================================================
  // one read at a time; unknown addresses read as absent entries
  always @(posedge core_clk) begin
    mem_rvalid <= 1'b0;
    if (rst) begin
      cnt <= 0;
      mem_rdata <= 64'h0;
    end else if (mem_req) begin
      addr_q <= mem_addr;
      cnt <= lat;
      n_reads <= n_reads + 1;
      mem_rdata <= ~mem_rdata;
    end else if (cnt == 1) begin
      cnt <= 0;
      mem_rvalid <= 1'b1;
      mem_rdata <= tab.exists(addr_q) ? tab[addr_q] : 64'h0;
    end else begin
      // data is garbage between answers so a late sample shows up
      cnt <= (cnt > 1) ? cnt - 1 : 0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

`default_nettype wire

// ===== dv/pmt_assertions.sv
// port-level checker for the paging translation block
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_chk #(
  parameter logic WIDE_SCHEME_AVAIL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] control_register_zero,
  input wire logic [31:0] id_leaf,
  input wire logic [31:0] data_register_d,
  input wire logic req_valid,
  input wire logic [31:0] req_lin,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic [`PMT_PA_W-1:0] resp_phys,
  input wire pmt_pkg::pmt_size_e resp_size,
  input wire logic page_fault_exception,
  input wire logic fault_pending,
  input wire logic handler_return,
  input wire logic mem_req,
  input wire logic mem_rvalid,
  input wire logic [63:0] mem_rdata
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // tracks an outstanding table read
  logic rd_open_ff;
  logic nxt_rd_open;
  always_comb begin
    nxt_rd_open = rd_open_ff;
    if (mem_req) nxt_rd_open = 1'b1;
    else if (mem_rvalid) nxt_rd_open = 1'b0;
  end
  always_ff @(posedge core_clk) begin
    rd_open_ff <= rst ? 1'b0 : nxt_rd_open;
  end

  // ==========================================================
  // assertions
  AST_RESP_PULSE: assert property (resp_valid |=> !resp_valid)
    else $error("response strobe longer than one cycle");
  AST_READY_WITH_RESP: assert property (resp_valid |-> req_ready)
    else $error("ready not back with the response");
  AST_TAKE_BUSY: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready stayed high after a take");
  AST_OFF_PASS: assert property (req_valid && req_ready && !control_register_zero[31]
    && !$past(control_register_zero[31]) |-> ##1 !mem_req ##1 (resp_valid
    && resp_size == pmt_pkg::pmt_sz_none && resp_phys == {4'h0, $past(req_lin, 2)}))
    else $error("untranslated request answered wrongly");
  AST_ABSENT_FAULT: assert property (rd_open_ff && mem_rvalid && !mem_rdata[0] |=> page_fault_exception)
    else $error("absent entry gave no fault");
  AST_PRESENT_OK: assert property (rd_open_ff && mem_rvalid && mem_rdata[0] |=> !page_fault_exception)
    else $error("fault on a present entry");
  AST_PEND_HOLD: assert property (fault_pending && !handler_return |=> fault_pending)
    else $error("fault pending dropped without handler return");
  AST_PEND_CLEAR: assert property (fault_pending && handler_return |=> !fault_pending && !resp_valid)
    else $error("fault pending not cleared by handler return");
  AST_ID_BIT: assert property (!$past(rst) |-> data_register_d ==
    (($past(id_leaf) == 32'h1) ? {14'h0, WIDE_SCHEME_AVAIL, 17'h0} : 32'h0))
    else $error("identification answer wrong");
  AST_ONE_READ: assert property (rd_open_ff |-> !mem_req)
    else $error("second table read while one is open");

  cover property (req_valid && req_ready);
  cover property (page_fault_exception);
  cover property (fault_pending && handler_return);
  cover property (resp_valid && resp_size == pmt_pkg::pmt_sz_2m);
endmodule

bind pmt_top pmt_chk #(.WIDE_SCHEME_AVAIL(WIDE_SCHEME_AVAIL)) chk_u (
  .core_clk, .rst, .control_register_zero, .id_leaf, .data_register_d, .req_valid, .req_lin,
  .req_ready, .resp_valid, .resp_phys, .resp_size, .page_fault_exception, .fault_pending,
  .handler_return, .mem_req, .mem_rvalid, .mem_rdata
);

`default_nettype wire

// ===== dv/pmt_top_tb.sv
// self-checking bench for the paging translation block
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_top_tb;
  // ==========================================================
  // signals
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] cr0 = 32'h0;
  logic [31:0] cr4 = 32'h0;
  logic [31:0] dir_base = 32'h0001_0000;
  logic tlb_flush = 1'b0;
  logic [31:0] id_leaf = 32'h0;
  logic req_valid = 1'b0;
  logic [31:0] req_lin = 32'h0;
  logic handler_return = 1'b0;
  logic [31:0] data_d;
  logic req_ready, resp_valid, pfe, fault_pending, mem_req, mem_rvalid;
  logic [`PMT_PA_W-1:0] resp_phys;
  logic [`PMT_PA_W-1:0] mem_addr;
  pmt_pkg::pmt_size_e resp_size;
  logic [31:0] fault_lin;
  logic [63:0] mem_rdata;
  int n_errors = 0;
  int total_checks = 0;
  int base_rd = 0;

  pmt_top dut_u (.core_clk(core_clk), .rst(rst), .control_register_zero(cr0),
    .control_register_four(cr4), .dir_base(dir_base), .tlb_flush(tlb_flush), .id_leaf(id_leaf),
    .data_register_d(data_d), .req_valid(req_valid), .req_lin(req_lin), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_phys(resp_phys), .resp_size(resp_size),
    .page_fault_exception(pfe), .fault_pending(fault_pending), .fault_lin(fault_lin),
    .handler_return(handler_return), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  pmt_mem_model mem_u (.core_clk(core_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // the mode is registered, so wait for it and the flush it causes to settle
  task automatic mode(input logic [31:0] c0, input logic [31:0] c4);
    @(negedge core_clk);
    cr0 = c0;
    cr4 = c4;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic go(input logic [31:0] lin);
    @(negedge core_clk);
    req_valid = 1'b1;
    req_lin = lin;
    base_rd = mem_u.n_reads;
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask

  task automatic wait_resp(input logic [35:0] ph, input pmt_pkg::pmt_size_e sz, input int nrd);
    int i;
    for (i = 0; i < 200 && resp_valid !== 1'b1; i++) @(negedge core_clk);
    chk("response", 64'h1, resp_valid);
    chk("phys", ph, resp_phys);
    chk("size", sz, resp_size);
    chk("reads", nrd, mem_u.n_reads - base_rd);
  endtask

  task automatic xl(input logic [31:0] lin, input logic [35:0] ph, input pmt_pkg::pmt_size_e sz,
    input int nrd);
    go(lin);
    wait_resp(ph, sz, nrd);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog and tests
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    $display("watchdog expired");
    end_of_test;
  end

  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    chk("ready", 64'h1, req_ready);
    chk("size", pmt_pkg::pmt_sz_none, resp_size);
    chk("id", 64'h0, data_d);
    $display("test reset finished");
    id_leaf = 32'h1;
    @(negedge core_clk);
    chk("id", 64'h0002_0000, data_d);
    id_leaf = 32'h2;
    @(negedge core_clk);
    chk("id", 64'h0, data_d);
    $display("test ident finished");
    mode(32'h0, 32'h30);
    xl(32'h1234_5678, 36'h0_1234_5678, pmt_pkg::pmt_sz_none, 0);
    $display("test off finished");
    // size bit set here must be ignored with no large pages
    mem_u.tab[36'h0_0001_0004] = 64'h0002_0081;
    mem_u.tab[36'h0_0002_000c] = 64'h0055_5001;
    mode(32'h8000_0000, 32'h0);
    xl(32'h0040_3abc, 36'h0_0055_5abc, pmt_pkg::pmt_sz_4k, 2);
    xl(32'h0040_3def, 36'h0_0055_5def, pmt_pkg::pmt_sz_4k, 0);
    @(negedge core_clk);
    tlb_flush = 1'b1;
    @(negedge core_clk);
    tlb_flush = 1'b0;
    xl(32'h0040_3abc, 36'h0_0055_5abc, pmt_pkg::pmt_sz_4k, 2);
    $display("test small finished");
    mem_u.tab[36'h0_0001_0008] = 64'h0c01_4081;
    mem_u.tab[36'h0_0001_0004] = 64'h0002_0001;
    mode(32'h8000_0000, 32'h10);
    xl(32'h0080_1234, 36'ha_0c00_1234, pmt_pkg::pmt_sz_4m, 1);
    // same 4-MByte page again: answered from the large buffer with no read
    xl(32'h0080_5678, 36'ha_0c00_5678, pmt_pkg::pmt_sz_4m, 0);
    xl(32'h0040_3abc, 36'h0_0055_5abc, pmt_pkg::pmt_sz_4k, 2);
    $display("test large finished");
    mem_u.lat = 5;
    mem_u.tab[36'h0_0001_0008] = 64'h3_0003_0001;
    mem_u.tab[36'h3_0003_0018] = 64'h5_0040_0081;
    mem_u.tab[36'h3_0003_0010] = 64'h3_0005_0001;
    mem_u.tab[36'h3_0005_0028] = 64'h7_1234_5001;
    mode(32'h8000_0000, 32'h20);
    xl(32'h4060_0123, 36'h5_0040_0123, pmt_pkg::pmt_sz_2m, 2);
    // same 2-MByte page again: large buffer hit
    xl(32'h4070_0abc, 36'h5_0050_0abc, pmt_pkg::pmt_sz_2m, 0);
    xl(32'h4040_5456, 36'h7_1234_5456, pmt_pkg::pmt_sz_4k, 3);
    $display("test extended finished");
    mem_u.lat = 1;
    mode(32'h8000_0000, 32'h0);
    go(32'h00c0_0111);
    for (int i = 0; i < 100 && pfe !== 1'b1; i++) @(negedge core_clk);
    chk("fault", 64'h1, pfe);
    chk("fault address", 64'h00c0_0111, fault_lin);
    mem_u.tab[36'h0_0001_000c] = 64'h0003_0001;
    mem_u.tab[36'h0_0003_0000] = 64'h0066_6001;
    repeat (5) @(negedge core_clk);
    chk("pending", 64'h1, fault_pending);
    chk("response", 64'h0, resp_valid);
    handler_return = 1'b1;
    @(negedge core_clk);
    handler_return = 1'b0;
    wait_resp(36'h0_0066_6111, pmt_pkg::pmt_sz_4k, 3);
    $display("test fault finished");
    end_of_test;
  end
endmodule

`default_nettype wire
